// file: logic/rspr_top.sv
// Purpose: Command answers and report scheduling of a timing receiver
// Assumes: Commands arrive decoded, one per valid cycle
// Notes:   One report at a time, bytes most significant first
// Operation
// - Last-fix request sends status, then selected fixes
// - Satellite data request answers data report
// - Data type codes two to six
// - Satellite id zero or one to 32
// - Ephemeris load refused
// - Tracking report only when data exists
// - Time report on request and five-second cycle
// - Time report: week time, week, offset
// - Extended week keeps counting past rollover
// - Unknown time: negative, sent on request only
// - Health code follows time source
// - XYZ single position report at every fix
// - Position report fields, time base selectable
// - Velocity report at every fix when enabled
// - Version report after power-on and request
// - Version years offset 1900 and 2000
// - Health with id report on reset, request, cycle
// - Status changes wait for next cycle
// - Health code values by condition
// - Error bits sticky until reset
// - On-request mode withholds automatic fix reports
// - Time type selects time base, UTC default
`timescale 1ns/1ps
`default_nettype none
module rspr_top
   import rspr_pkg::*;
#(
   parameter longint          AUTO_CYCLES_P = rspr_pkg::AUTO_CYCLES,
   parameter logic [7:0]      MACHINE_ID    = 8'h5A, // Arbitrary value
   parameter logic [7:0]      NAV_MAJOR     = 8'h01,
   parameter logic [7:0]      NAV_MINOR     = 8'h00,
   parameter logic [7:0]      NAV_MONTH     = 8'h01,
   parameter logic [7:0]      NAV_DAY       = 8'h01,
   parameter int              NAV_YEAR      = 2001,
   parameter logic [7:0]      SIG_MAJOR     = 8'h01,
   parameter logic [7:0]      SIG_MINOR     = 8'h00,
   parameter logic [7:0]      SIG_MONTH     = 8'h01,
   parameter logic [7:0]      SIG_DAY       = 8'h01,
   parameter int              SIG_YEAR      = 2001
) (
   input  wire logic                   CORE_CLK,
   input  wire logic                   RST,
   input  wire rspr_pkg::rspr_cmd_type CMD,
   input  wire logic                   FIX_EVENT,
   input  wire rspr_pkg::rspr_fix_type FIX,
   input  wire logic                   OPT_LOAD,
   input  wire logic [31:0]            OPT_WORD,
   input  wire logic                   SOFT_RESET,
   input  wire rspr_pkg::rspr_tsrc_type TIME_SRC,
   input  wire logic [31:0]            TIME_OF_WEEK,
   input  wire logic [9:0]             WEEK,
   input  wire logic                   WEEK_VALID,
   input  wire logic [31:0]            UTC_OFFSET,
   input  wire logic                   NEED_INIT,
   input  wire logic                   POSITION_DILUTION_HIGH,
   input  wire logic [2:0]             USABLE_SATS,
   input  wire logic                   CHOSEN_UNUSABLE,
   input  wire logic                   BATTERY_BACKED_MEMORY_FAIL,
   input  wire logic                   ANT_SHORT_PIN,
   input  wire logic                   RTC_UNAVAIL,
   input  wire logic                   ALM_INCOMPLETE,
   input  wire logic                   TRACK_AVAIL,
   input  wire logic [31:0]            TRACK_DATA,
   input  wire logic                   RPT_READY,
   output var  rspr_pkg::rspr_rpt_type RPT,
   output var  logic                   LOAD_ACCEPT,
   output var  logic                   CMD_REJECT
);
   import rspr_pkg::*;

   rspr_state_type     state_r;
   logic [NUM_RPT-1:0] pend_r;
   logic [NUM_RPT-1:0] pend_set;
   logic [NUM_RPT-1:0] pend_clr;
   logic [31:0]        opt_r;
   rspr_fix_type       fix_r;
   logic [7:0]         err_r;
   logic               boot_r;
   logic [5:0]         epoch_r;
   logic [9:0]         week_r;
   logic [31:0]        cnt_r;
   logic               tick;
   logic [7:0]         sys_type_r;
   logic [7:0]         sys_sat_r;
   logic [7:0]         trk_sat_r;
   logic [BUF_W-1:0]   buf_r;
   logic [BUF_W-1:0]   buf_nxt;
   logic [4:0]         left_r;
   logic [4:0]         len_nxt;
   logic [7:0]         id_r;
   logic [7:0]         id_nxt;
   logic [3:0]         sel;
   logic               any;
   logic               ant_short;
   logic [7:0]         health_code;
   logic               time_known;
   logic               pos_sel;
   logic               vel_sel;
   logic               fix_onreq;
   logic [31:0]        tfix;
   logic [31:0]        tow_rep;
   logic [15:0]        ext_week;
   logic               beat;
   logic               cmd_ok;
   logic               load_go;

   rspr_sync u_ant_sync (
      .clk  (CORE_CLK),
      .rst  (RST),
      .din  (ANT_SHORT_PIN),
      .dout (ant_short)
   );

   assign time_known = (TIME_SRC != TS_NONE);
   assign pos_sel    = opt_r[OPT_POS_XYZ_BIT] && !opt_r[OPT_PREC_BIT];
   assign vel_sel    = opt_r[OPT_VEL_XYZ_BIT];
   assign fix_onreq  = opt_r[OPT_FIX_ONREQ_BIT];
   assign tfix       = opt_r[OPT_TIME_UTC_BIT] ? fix_r.t_utc : fix_r.t_gps;
   assign tow_rep    = time_known ? TIME_OF_WEEK : (TIME_OF_WEEK | FLOAT_SIGN);
   assign ext_week   = {epoch_r, week_r};
   assign tick       = (cnt_r == 32'(AUTO_CYCLES_P - 1));
   assign beat       = (state_r == ST_SEND) && RPT_READY;
   assign load_go    = (state_r == ST_IDLE) && any;
   // Type and satellite checks for the data command
   assign cmd_ok     = (CMD.dtype >= DT_ALMANAC) && (CMD.dtype <= DT_EPHEMERIS)
                       && (CMD.sat <= SAT_MAX);

   // Health code from time source and tracking condition
   always_comb begin
      health_code = HC_NO_TIME;
      if (TIME_SRC == TS_SOLN) begin
         health_code = HC_FIXING;
      end else if (TIME_SRC == TS_SAT) begin
         if (NEED_INIT) begin
            health_code = HC_NEED_INIT;
         end else if (CHOSEN_UNUSABLE) begin
            health_code = HC_CHOSEN_BAD;
         end else if (USABLE_SATS < SATS_ENOUGH) begin
            health_code = HC_SATS_BASE + {5'h00, USABLE_SATS};
         end else begin
            health_code = HC_DOP_HIGH;
         end
      end
   end

   // Options; time base defaults to UTC
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         opt_r <= OPT_RESET;
      end else if (OPT_LOAD) begin
         opt_r <= OPT_WORD;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         fix_r <= '0;
      end else if (FIX_EVENT) begin
         fix_r <= FIX;
      end
   end

   // Week rollover extends the count
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         epoch_r <= 6'h00;
         week_r  <= 10'h000;
      end else if (WEEK_VALID) begin
         week_r <= WEEK;
         if (WEEK < week_r) begin
            epoch_r <= epoch_r + 6'h01;
         end
      end
   end

   // Strap caught on the first edge after release
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         boot_r <= 1'b1;
         err_r  <= 8'h00;
      end else begin
         boot_r <= 1'b0;
         if (boot_r && BATTERY_BACKED_MEMORY_FAIL) begin
            err_r[ERR_MEMORY_BIT] <= 1'b1;
         end
         if (ant_short) begin
            err_r[ERR_ANT_BIT] <= 1'b1;
         end
      end
   end

   // Free-running cycle; changes in between only show at the next tick
   always_ff @(posedge CORE_CLK) begin
      if (RST || tick) begin
         cnt_r <= 32'h0000_0000;
      end else begin
         cnt_r <= cnt_r + 32'h0000_0001;
      end
   end

   // Requests for reports
   always_comb begin
      pend_set = '0;
      if (CMD.valid) begin
         if (CMD.id == CMD_LAST_FIX) begin
            pend_set[P_FIXST] = 1'b1;
            pend_set[P_POS]   = pos_sel;
            pend_set[P_VEL]   = vel_sel;
         end else if (CMD.id == CMD_SYS_DATA) begin
            pend_set[P_SYS] = cmd_ok && (CMD.op == OP_REQUEST);
         end else if (CMD.id == CMD_TRACK) begin
            pend_set[P_TRK] = TRACK_AVAIL && (CMD.sat <= SAT_MAX);
         end else if (CMD.id == CMD_TIME) begin
            pend_set[P_TIME] = 1'b1;
         end else if (CMD.id == CMD_VERSION) begin
            pend_set[P_VER] = 1'b1;
         end else if (CMD.id == CMD_HEALTH) begin
            pend_set[P_HLTH] = 1'b1;
            pend_set[P_ID]   = 1'b1;
         end
      end
      if (FIX_EVENT && !fix_onreq) begin
         pend_set[P_POS] = pend_set[P_POS] | pos_sel;
         pend_set[P_VEL] = pend_set[P_VEL] | vel_sel;
      end
      if (tick) begin
         pend_set[P_TIME] = pend_set[P_TIME] | time_known;
         pend_set[P_HLTH] = 1'b1;
         pend_set[P_ID]   = 1'b1;
      end
      if (boot_r) begin
         pend_set[P_VER] = 1'b1;
      end
      if (boot_r || SOFT_RESET) begin
         pend_set[P_HLTH] = 1'b1;
         pend_set[P_ID]   = 1'b1;
      end
   end

   // Lowest pending slot is served first
   always_comb begin
      sel = 4'h0;
      any = 1'b0;
      for (int i = NUM_RPT - 1; i >= 0; i--) begin
         if (pend_r[i]) begin
            sel = 4'(i);
            any = 1'b1;
         end
      end
      pend_clr = '0;
      if (load_go) begin
         pend_clr[sel] = 1'b1;
      end
   end

   // A new request in the serving cycle survives
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         pend_r <= '0;
      end else begin
         pend_r <= (pend_r & ~pend_clr) | pend_set;
      end
   end

   // Satellite data fields; in-range loads other than ephemeris are accepted
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         sys_type_r  <= 8'h00;
         sys_sat_r   <= 8'h00;
         trk_sat_r   <= 8'h00;
         LOAD_ACCEPT <= 1'b0;
         CMD_REJECT  <= 1'b0;
      end else begin
         LOAD_ACCEPT <= 1'b0;
         CMD_REJECT  <= 1'b0;
         if (CMD.valid && CMD.id == CMD_SYS_DATA) begin
            if (!cmd_ok || (CMD.op != OP_REQUEST && CMD.op != OP_LOAD)) begin
               CMD_REJECT <= 1'b1;
            end else if (CMD.op == OP_LOAD) begin
               LOAD_ACCEPT <= (CMD.dtype != DT_EPHEMERIS);
               CMD_REJECT  <= (CMD.dtype == DT_EPHEMERIS);
            end else begin
               sys_type_r <= CMD.dtype;
               sys_sat_r  <= CMD.sat;
            end
         end
         if (CMD.valid && CMD.id == CMD_TRACK) begin
            trk_sat_r <= CMD.sat;
         end
      end
   end

   // Payload left-aligned so the top byte goes first
   always_comb begin
      buf_nxt = '0;
      len_nxt = LEN_ONE;
      id_nxt  = RPT_FIX_STATUS;
      case (sel)
         4'(P_FIXST): begin
            buf_nxt[BUF_W-1 -: LEN_FIXST*BYTE_W] = {tfix, ext_week};
            len_nxt = LEN_FIXST;
         end
         4'(P_POS): begin
            buf_nxt[BUF_W-1 -: LEN_POS*BYTE_W] = {fix_r.x, fix_r.y, fix_r.z, tfix};
            len_nxt = LEN_POS;
            id_nxt  = RPT_POS_XYZ;
         end
         4'(P_VEL): begin
            buf_nxt = {fix_r.vx, fix_r.vy, fix_r.vz, fix_r.bias, tfix};
            len_nxt = LEN_VEL;
            id_nxt  = RPT_VEL_XYZ;
         end
         4'(P_SYS): begin
            buf_nxt[BUF_W-1 -: LEN_SYS*BYTE_W] = {OP_REQUEST, sys_type_r, sys_sat_r, 8'h00};
            len_nxt = LEN_SYS;
            id_nxt  = RPT_SYS_DATA;
         end
         4'(P_TRK): begin
            buf_nxt[BUF_W-1 -: LEN_TRK*BYTE_W] = {trk_sat_r, TRACK_DATA};
            len_nxt = LEN_TRK;
            id_nxt  = RPT_TRACK;
         end
         4'(P_TIME): begin
            buf_nxt[BUF_W-1 -: LEN_TIME*BYTE_W] = {tow_rep, ext_week, UTC_OFFSET};
            len_nxt = LEN_TIME;
            id_nxt  = RPT_TIME;
         end
         4'(P_VER): begin
            buf_nxt[BUF_W-1 -: LEN_VER*BYTE_W] = {NAV_MAJOR, NAV_MINOR, NAV_MONTH, NAV_DAY,
               8'(NAV_YEAR - YEAR_BASE_NAV), SIG_MAJOR, SIG_MINOR, SIG_MONTH, SIG_DAY,
               8'(SIG_YEAR - YEAR_BASE_SIG)};
            len_nxt = LEN_VER;
            id_nxt  = RPT_VERSION;
         end
         4'(P_HLTH): begin
            buf_nxt[BUF_W-1 -: LEN_HLTH*BYTE_W] = {health_code, err_r};
            len_nxt = LEN_HLTH;
            id_nxt  = RPT_HEALTH;
         end
         4'(P_ID): begin
            buf_nxt[BUF_W-1 -: LEN_ID*BYTE_W] = {MACHINE_ID,
               4'h0, ALM_INCOMPLETE, 1'b0, RTC_UNAVAIL, 1'b0, 8'h00};
            len_nxt = LEN_ID;
            id_nxt  = RPT_ID_STATUS;
         end
         default: begin
            buf_nxt = '0;
         end
      endcase
   end

   // Serialiser; content frozen at load so a packet never mixes two fixes
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         state_r <= ST_IDLE;
         buf_r   <= '0;
         left_r  <= 5'h00;
         id_r    <= 8'h00;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (any) begin
                  state_r <= ST_SEND;
                  buf_r   <= buf_nxt;
                  left_r  <= len_nxt;
                  id_r    <= id_nxt;
               end
            end
            ST_SEND: begin
               if (RPT_READY) begin
                  buf_r  <= buf_r << BYTE_W;
                  left_r <= left_r - LEN_ONE;
                  if (left_r == LEN_ONE) begin
                     state_r <= ST_IDLE;
                  end
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   always_comb begin
      RPT.valid = (state_r == ST_SEND);
      RPT.id    = id_r;
      RPT.data  = buf_r[BUF_W-1 -: BYTE_W];
      RPT.last  = (state_r == ST_SEND) && (left_r == LEN_ONE);
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   sequence s_lastfix_cmd;
      CMD.valid && CMD.id == CMD_LAST_FIX;
   endsequence

   sequence s_beat_more;
      beat && !RPT.last;
   endsequence

   AST_LASTFIX_PEND:
      assert property (s_lastfix_cmd |=> pend_r[P_FIXST])
      else $error("last-fix command did not queue the status report");
   AST_SYS_PEND:
      assert property (CMD.valid && CMD.id == CMD_SYS_DATA && CMD.op == OP_REQUEST
                       && cmd_ok |=> pend_r[P_SYS])
      else $error("data request did not queue the data report");
   AST_EPH_REFUSED:
      assert property (CMD.valid && CMD.id == CMD_SYS_DATA && CMD.op == OP_LOAD
                       && CMD.dtype == DT_EPHEMERIS |=> CMD_REJECT && !LOAD_ACCEPT)
      else $error("ephemeris load was not refused");
   AST_TRACK_NODATA:
      assert property (CMD.valid && CMD.id == CMD_TRACK && !TRACK_AVAIL
                       && !pend_r[P_TRK] |=> !pend_r[P_TRK])
      else $error("tracking report queued without data");
   AST_TICK_TIME:
      assert property (tick && time_known |=> pend_r[P_TIME])
      else $error("cycle did not queue the time report");
   AST_WEEK_WRAP:
      assert property (WEEK_VALID && WEEK == 10'h000 && week_r == WEEK_LAST
                       |=> epoch_r == $past(epoch_r) + 6'h01)
      else $error("extended week lost the rollover");
   AST_TOW_NEG:
      assert property (load_go && sel == 4'(P_TIME) && !time_known
                       |=> RPT.valid && RPT.data[BYTE_W-1])
      else $error("unknown time not reported negative");
   AST_HEALTH_SOLN:
      assert property (TIME_SRC == TS_SOLN |-> health_code == HC_FIXING)
      else $error("health code wrong for full solution");
   AST_SOFT_HEALTH:
      assert property (SOFT_RESET |=> pend_r[P_HLTH] && pend_r[P_ID])
      else $error("soft reset did not queue health and id reports");
   AST_ANT_STICKY:
      assert property ($rose(err_r[ERR_ANT_BIT]) |=> err_r[ERR_ANT_BIT] [*4])
      else $error("antenna fault flag did not hold");
   AST_ONREQ_HOLD:
      assert property (FIX_EVENT && fix_onreq && !CMD.valid && !pend_r[P_POS]
                       |=> !pend_r[P_POS])
      else $error("fix report queued in on-request mode");
   AST_BYTE_ORDER:
      assert property (s_beat_more |=> RPT.data == $past(buf_r[BUF_W-BYTE_W-1 -: BYTE_W]))
      else $error("payload byte order broken");
endmodule
`default_nettype wire

// file: logic/rspr_pkg.sv
// Purpose: Shared constants and types of the receiver status packet responder
// Assumes: Packet framing is done outside; commands arrive already decoded
// Notes:   Report payloads leave most significant byte first
package rspr_pkg;

   // Command identifiers
   localparam logic [7:0] CMD_LAST_FIX  = 8'h37;
   localparam logic [7:0] CMD_SYS_DATA  = 8'h38;
   localparam logic [7:0] CMD_TRACK     = 8'h3C;
   localparam logic [7:0] CMD_TIME      = 8'h21;
   localparam logic [7:0] CMD_VERSION   = 8'h1F;
   localparam logic [7:0] CMD_HEALTH    = 8'h26;

   // Report identifiers
   localparam logic [7:0] RPT_FIX_STATUS = 8'h57;
   localparam logic [7:0] RPT_POS_XYZ    = 8'h42;
   localparam logic [7:0] RPT_VEL_XYZ    = 8'h43;
   localparam logic [7:0] RPT_SYS_DATA   = 8'h58;
   localparam logic [7:0] RPT_TRACK      = 8'h5C;
   localparam logic [7:0] RPT_TIME       = 8'h41;
   localparam logic [7:0] RPT_VERSION    = 8'h45;
   localparam logic [7:0] RPT_HEALTH     = 8'h46;
   localparam logic [7:0] RPT_ID_STATUS  = 8'h4B;

   // Pending slots, lower index wins
   localparam int P_FIXST = 0;
   localparam int P_POS   = 1;
   localparam int P_VEL   = 2;
   localparam int P_SYS   = 3;
   localparam int P_TRK   = 4;
   localparam int P_TIME  = 5;
   localparam int P_VER   = 6;
   localparam int P_HLTH  = 7;
   localparam int P_ID    = 8;
   localparam int NUM_RPT = 9;

   // Payload lengths in bytes
   localparam logic [4:0] LEN_FIXST = 5'h06;
   localparam logic [4:0] LEN_POS   = 5'h10;
   localparam logic [4:0] LEN_VEL   = 5'h14;
   localparam logic [4:0] LEN_SYS   = 5'h04;
   localparam logic [4:0] LEN_TRK   = 5'h05;
   localparam logic [4:0] LEN_TIME  = 5'h0A;
   localparam logic [4:0] LEN_VER   = 5'h0A;
   localparam logic [4:0] LEN_HLTH  = 5'h02;
   localparam logic [4:0] LEN_ID    = 5'h03;
   localparam logic [4:0] LEN_ONE   = 5'h01;
   localparam int         BUF_W     = 160;
   localparam int         BYTE_W    = 8;

   // Satellite data command fields
   localparam logic [7:0] OP_REQUEST    = 8'h01;
   localparam logic [7:0] OP_LOAD       = 8'h02;
   localparam logic [7:0] DT_ALMANAC    = 8'h02;
   localparam logic [7:0] DT_EPHEMERIS  = 8'h06;
   localparam logic [7:0] SAT_MAX       = 8'h20;

   // Output option word: byte 0 position, byte 1 velocity, byte 2 timing
   localparam int          OPT_POS_XYZ_BIT  = 0;
   localparam int          OPT_PREC_BIT     = 4;
   localparam int          OPT_VEL_XYZ_BIT  = 8;
   localparam int          OPT_TIME_UTC_BIT = 16;
   localparam int          OPT_FIX_ONREQ_BIT = 18;
   localparam logic [31:0] OPT_RESET        = 32'h0001_0101;

   // Health codes
   localparam logic [7:0] HC_FIXING      = 8'h00;
   localparam logic [7:0] HC_NO_TIME     = 8'h01;
   localparam logic [7:0] HC_NEED_INIT   = 8'h02;
   localparam logic [7:0] HC_DOP_HIGH    = 8'h03;
   localparam logic [7:0] HC_SATS_BASE   = 8'h08;
   localparam logic [7:0] HC_CHOSEN_BAD  = 8'h0C;
   localparam logic [2:0] SATS_ENOUGH    = 3'h4;

   // Error and status bit positions
   localparam int ERR_MEMORY_BIT = 0;
   localparam int ERR_ANT_BIT    = 4;
   localparam int ST1_RTC_BIT    = 1;
   localparam int ST1_ALM_BIT    = 3;

   // Time and week
   localparam logic [31:0] FLOAT_SIGN   = 32'h8000_0000;
   localparam logic [9:0]  WEEK_LAST    = 10'h3FF;
   localparam int          YEAR_BASE_NAV = 1900;
   localparam int          YEAR_BASE_SIG = 2000;

   // Automatic cycle
   localparam longint CLK_HZ        = 64'd100_000_000;
   localparam longint AUTO_PERIOD_S = 64'd5;
   localparam longint AUTO_CYCLES   = AUTO_PERIOD_S * CLK_HZ;

   typedef enum logic [1:0] {
      TS_NONE   = 2'b00,
      TS_APPROX = 2'b01,
      TS_SOLN   = 2'b11,
      TS_SAT    = 2'b10
   } rspr_tsrc_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SEND = 2'b01
   } rspr_state_type;

   typedef struct packed {
      logic       valid;
      logic [7:0] id;
      logic [7:0] op;
      logic [7:0] dtype;
      logic [7:0] sat;
      logic [7:0] len;
   } rspr_cmd_type;

   typedef struct packed {
      logic [31:0] x;
      logic [31:0] y;
      logic [31:0] z;
      logic [31:0] t_gps;
      logic [31:0] t_utc;
      logic [31:0] vx;
      logic [31:0] vy;
      logic [31:0] vz;
      logic [31:0] bias;
   } rspr_fix_type;

   typedef struct packed {
      logic       valid;
      logic [7:0] id;
      logic [7:0] data;
      logic       last;
   } rspr_rpt_type;

endpackage

// file: logic/rspr_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Input is asynchronous to CORE_CLK
// Notes:   Output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module rspr_sync (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic din,
   output var  logic dout
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Stage one is read by stage two only
   always_ff @(posedge clk) begin
      if (rst) begin
         dout <= 1'b0;
      end else if (s2_r == s3_r) begin
         dout <= s3_r;
      end
   end
endmodule
`default_nettype wire

// file: verification/rspr_host.sv
// Purpose: Host side sink that collects report packets
// Assumes: One report at a time, last byte flagged
// Notes:   Slow mode takes a byte only every other cycle
`timescale 1ns/1ps
`default_nettype none
module rspr_host
   import rspr_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   slow,
   input  wire rspr_pkg::rspr_rpt_type rpt,
   output var  logic                   ready
);
   logic [159:0] cur_r;
   logic [159:0] pay [256];
   int           cnt [256];
   initial begin
      ready = 1'b0;
      cur_r = '0;
      foreach (cnt[i]) cnt[i] = 0;
   end
   always @(posedge clk) begin
      ready <= slow ? ~ready : 1'b1;
      if (rpt.valid && ready) begin
         cur_r <= rpt.last ? '0 : {cur_r[151:0], rpt.data};
         if (rpt.last) begin
            pay[rpt.id] <= {cur_r[151:0], rpt.data};
            cnt[rpt.id] <= cnt[rpt.id] + 1;
         end
      end
   end
endmodule
`default_nettype wire

// file: verification/rspr_top_tb.sv
// Purpose: Scenario bench of the status packet responder
// Assumes: Automatic cycle shortened so that one falls after the requested scenarios
// Notes:   Fixed waits cover the longest report with margin
`timescale 1ns/1ps
`default_nettype none
module rspr_top_tb;
   import rspr_pkg::*;
   logic clk = 1'b0, rst = 1'b1, fe = 1'b0, ol = 1'b0, sr = 1'b0, wv = 1'b0, slow = 1'b0;
   logic bb = 1'b1, ant = 1'b0, ni = 1'b0, dop = 1'b0, cu = 1'b0, ta = 1'b1, rdy, la, cr;
   logic rtc = 1'b1, alm = 1'b1;
   logic [31:0] ow = OPT_RESET, wt = 32'h4000_0000, uo = 32'h4180_0000;
   logic [9:0] wk = 10'h3FF;
   logic [2:0] us = 3'h2;
   rspr_tsrc_type ts = TS_NONE;
   rspr_cmd_type c = '0;
   rspr_fix_type fix = {96'h1, 32'h4200_0000, 32'h4100_0000, 128'h2};
   rspr_rpt_type rpt;
   int miscompares = 0, checks_done = 0, cyc = 0;
   rspr_top #(.AUTO_CYCLES_P(64'd600)) i_dut (.CORE_CLK(clk), .RST(rst), .CMD(c),
      .FIX_EVENT(fe), .FIX(fix), .OPT_LOAD(ol), .OPT_WORD(ow), .SOFT_RESET(sr),
      .TIME_SRC(ts), .TIME_OF_WEEK(wt), .WEEK(wk), .WEEK_VALID(wv), .UTC_OFFSET(uo),
      .NEED_INIT(ni), .POSITION_DILUTION_HIGH(dop), .USABLE_SATS(us), .CHOSEN_UNUSABLE(cu),
      .BATTERY_BACKED_MEMORY_FAIL(bb), .ANT_SHORT_PIN(ant), .RTC_UNAVAIL(rtc),
      .ALM_INCOMPLETE(alm), .TRACK_AVAIL(ta), .TRACK_DATA(32'h1234_5678), .RPT_READY(rdy),
      .RPT(rpt), .LOAD_ACCEPT(la), .CMD_REJECT(cr));
   rspr_host i_host (.clk(clk), .slow(slow), .rpt(rpt), .ready(rdy));
   initial forever #5 clk = ~clk;
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Host drives every command field, valid for one cycle
   task send(input logic [7:0] id, op, dt, sat, len);
      tick(1);
      c <= '{1'b1, id, op, dt, sat, len};
      tick(1);
      c.valid <= 1'b0;
   endtask
   task t_boot;
      tick(80);
      chk(i_host.cnt[8'h45], 1);
      chk(i_host.pay[8'h45][47:40], 8'h65);
      chk(i_host.pay[8'h45][7:0], 8'h01);
      chk(i_host.pay[8'h46][15:0], 16'h0101);
      chk(i_host.cnt[8'h4B], 1);
      chk(i_host.pay[8'h4B][15:8], 8'h0A);
      $display("boot done");
   endtask
   task t_time;
      wv <= 1'b1;
      tick(1);
      wk <= 10'h000;
      tick(1);
      wv <= 1'b0;
      send(CMD_TIME, 8'h00, 8'h00, 8'h00, 8'h00);
      tick(40);
      chk(i_host.pay[8'h41][79:48], 32'hC000_0000);
      chk(i_host.pay[8'h41][47:32], 16'h0400);
      chk(i_host.pay[8'h41][31:0], uo);
      $display("time done");
   endtask
   task t_sys;
      send(CMD_SYS_DATA, OP_REQUEST, DT_EPHEMERIS, SAT_MAX, 8'h00);
      tick(20);
      chk(i_host.pay[8'h58][31:0], 32'h0106_2000);
      send(CMD_SYS_DATA, OP_LOAD, DT_EPHEMERIS, 8'h00, 8'h04);
      chk(cr, 1'b1);
      send(CMD_SYS_DATA, OP_REQUEST, DT_ALMANAC, 8'h21, 8'h00);
      chk(cr, 1'b1);
      send(CMD_SYS_DATA, OP_REQUEST, 8'h07, 8'h00, 8'h00);
      chk(cr, 1'b1);
      send(CMD_SYS_DATA, OP_LOAD, DT_ALMANAC, 8'h00, 8'h04);
      chk(la, 1'b1);
      ta <= 1'b0;
      send(CMD_TRACK, 8'h03, 8'h00, 8'h00, 8'h00);
      tick(20);
      chk(i_host.cnt[8'h5C], 0);
      chk(i_host.cnt[8'h58], 1);
      ta <= 1'b1;
      send(CMD_TRACK, 8'h00, 8'h00, 8'h03, 8'h00);
      tick(20);
      chk(i_host.cnt[8'h5C], 1);
      chk(i_host.pay[8'h5C][39:8], 32'h0312_3456);
      $display("system data done");
   endtask
   task t_fix;
      fe <= 1'b1;
      tick(1);
      fe <= 1'b0;
      tick(60);
      chk(i_host.cnt[8'h42], 1);
      chk(i_host.pay[8'h42][31:0], 32'h4100_0000);
      chk(i_host.pay[8'h43][31:0], 32'h4100_0000);
      ow <= OPT_RESET | 32'h0004_0000;
      ol <= 1'b1;
      tick(1);
      ol <= 1'b0;
      fe <= 1'b1;
      tick(1);
      fe <= 1'b0;
      tick(60);
      chk(i_host.cnt[8'h42], 1);
      send(CMD_LAST_FIX, 8'h00, 8'h00, 8'h00, 8'h00);
      tick(80);
      chk(i_host.cnt[8'h57], 1);
      chk(i_host.cnt[8'h43], 2);
      $display("fix done");
   endtask
   task t_health;
      slow <= 1'b1;
      ant <= 1'b1;
      tick(10);
      ant <= 1'b0;
      ts <= TS_SAT;
      send(CMD_HEALTH, 8'h00, 8'h00, 8'h00, 8'h00);
      tick(40);
      chk(i_host.pay[8'h46][15:0], 16'h0A11);
      chk(i_host.cnt[8'h4B], 2);
      $display("health done");
   endtask
   // Status change well before the first cycle, which falls at cycle 600
   task t_auto;
      ni <= 1'b1;
      tick(100);
      chk(i_host.cnt[8'h46], 2);
      tick(100);
      chk(i_host.cnt[8'h41], 2);
      chk(i_host.pay[8'h41][79:48], wt);
      chk(i_host.pay[8'h46][15:8], HC_NEED_INIT);
      chk(i_host.cnt[8'h4B], 3);
      sr <= 1'b1;
      tick(1);
      sr <= 1'b0;
      tick(40);
      chk(i_host.cnt[8'h46], 4);
      $display("auto cycle done");
   endtask
   task finish_test;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Ceiling well above the seven hundred or so cycles the scenarios need
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         finish_test;
      end
   end
   initial begin
      tick(6);
      rst <= 1'b0;
      t_boot;
      t_time;
      t_sys;
      t_fix;
      t_health;
      t_auto;
      finish_test;
   end
endmodule
`default_nettype wire
